// ===== tb/dbp_ctl_model.sv
// Memory controller model on the port's pins
`timescale 1ns/1ps
module dbp_ctl_model #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 21,
    parameter int LANES  = 2
) (
    // Clock and device outputs
    input  wire logic              core_clk,
    input  wire logic              echo_out,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic              output_valid,
    // Command and write pins
    output logic                   load_n = 1'b1,
    output logic                   read_not_write = 1'b0,
    output logic      [ADDR_W-1:0] addr = '0,
    output logic      [DATA_W-1:0] dq_in = '0,
    output logic      [LANES-1:0]  byte_write_sel_n = '1
);
    // Move to just after the next rising edge
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    // Load in a true-edge cycle, then scramble the command pins
    task automatic issue(input logic rnw, input logic [ADDR_W-1:0] a);
        step();
        if (!echo_out) begin
            step();
        end
        load_n = 1'b0;
        read_not_write = rnw;
        addr = {a[0], a[ADDR_W-1:1]};
        step();
        load_n = 1'b1;
        read_not_write = !rnw;
        addr = ~a;
    endtask
    // Write burst, one select pair per beat
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                      input logic [LANES-1:0] s0, s1);
        issue(1'b0, a);
        step();
        dq_in = d0;
        byte_write_sel_n = s0;
        step();
        dq_in = d1;
        byte_write_sel_n = s1;
        step();
        dq_in = ~d1;
        byte_write_sel_n = '1;
    endtask
    // Read burst, both beats captured
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q0, q1,
                      output logic v);
        issue(1'b1, a);
        step();
        q0 = dq_out;
        v = output_valid;
        step();
        q1 = dq_out;
        v = v & output_valid;
    endtask
    // Read load in a complement cycle, beats counted
    task automatic odd_load(output int beats);
        beats = 0;
        step();
        if (echo_out) begin
            step();
        end
        load_n = 1'b0;
        read_not_write = 1'b1;
        step();
        load_n = 1'b1;
        repeat (4) begin
            step();
            beats += int'(output_valid !== 1'b0);
        end
    endtask
endmodule

// ===== tb/dbp_port_chk.sv
// Port checker for the burst DDR static RAM port
`timescale 1ns/1ps
module dbp_port_chk #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 21,
    parameter int LANES  = 2
) (
    // Clock, reset, command and write pins
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic              load_n,
    input wire logic              read_not_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [LANES-1:0]  byte_write_sel_n,
    // Read side and echoes
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              output_valid,
    input wire logic              echo_out,
    input wire logic              echo_out_n
);
    logic rd_take;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Read load taken on a true edge
    assign rd_take = !load_n && read_not_write && echo_out;
    a_valid_tracks_oe:
        assert property (output_valid == dq_oe) else $error("valid and enable differ");
    a_echo_pair:
        assert property (echo_out_n == !echo_out) else $error("echo pair not inverse");
    a_echo_toggles:
        assert property ($past(rst_b) |-> echo_out != $past(echo_out)) else $error("echo stuck");
    a_read_start:
        assert property (rd_take |-> ##2 dq_oe ##1 dq_oe) else $error("read beats missing");
    a_write_quiet:
        assert property (!load_n && !read_not_write && echo_out |-> ##2 !output_valid[*2])
        else $error("valid during write");
    a_oe_cause:
        assert property ($rose(dq_oe) |-> $past(rd_take, 2)) else $error("drive without read");
    a_beat_pair:
        assert property ($rose(dq_oe) |=> dq_oe) else $error("single read beat");
    a_idle_zero:
        assert property (!dq_oe |-> dq_out == '0) else $error("data while released");
endmodule
bind dbp_port dbp_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .load_n(load_n), .read_not_write(read_not_write),
    .addr(addr), .dq_in(dq_in), .byte_write_sel_n(byte_write_sel_n), .dq_out(dq_out),
    .dq_oe(dq_oe), .output_valid(output_valid), .echo_out(echo_out), .echo_out_n(echo_out_n));

// ===== tb/testbench.sv
// Bench for the burst DDR static RAM port
`timescale 1ns/1ps
module testbench;
    import dbp_pkg::*;
    localparam int DW = DBP_DATA_W_NARROW;
    localparam int AW = 4;
    logic          core_clk, rst_b, load_n, read_not_write, dq_oe, output_valid;
    logic          echo_out, echo_out_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_in, dq_out;
    logic [1:0]    byte_write_sel_n;
    int            error_cnt = 0;
    int            samples_checked = 0;
    int            cycles = 0;
    dbp_port #(.DATA_W(DW), .ADDR_W(AW)) u_dbp_port (
        .core_clk(core_clk), .rst_b(rst_b), .load_n(load_n), .read_not_write(read_not_write),
        .addr(addr), .dq_in(dq_in), .byte_write_sel_n(byte_write_sel_n), .dq_out(dq_out),
        .dq_oe(dq_oe), .output_valid(output_valid), .echo_out(echo_out), .echo_out_n(echo_out_n));
    dbp_ctl_model #(.DATA_W(DW), .ADDR_W(AW)) u_ctl (
        .core_clk(core_clk), .echo_out(echo_out), .dq_out(dq_out), .output_valid(output_valid),
        .load_n(load_n), .read_not_write(read_not_write), .addr(addr), .dq_in(dq_in),
        .byte_write_sel_n(byte_write_sel_n));
    // Clock and hang guard
    always #10 core_clk = !core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            close_out();
        end
    end
    // Comparison and verdict
    task automatic check(input string what, input logic [DW-1:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [DW-1:0] pat(int i, int b);
        return DW'(i) * 18'h0_0445 ^ DW'(b) * 18'h1_2345 ^ 18'h2_5a5a;
    endfunction
    // Full bursts at low, middle and top address
    task automatic t_full();
        logic [AW-1:0] at [3] = '{4'h0, 4'h5, 4'hf};
        logic [DW-1:0] q0, q1;
        logic          v;
        for (int i = 0; i < 3; i++) begin
            u_ctl.wr(at[i], pat(i, 0), pat(i, 1), 2'h0, 2'h0);
        end
        for (int i = 0; i < 3; i++) begin
            u_ctl.rd(at[i], q0, q1, v);
            check("word0", q0, pat(i, 0));
            check("word1", q1, pat(i, 1));
            check("valid", v, 1'b1);
        end
        $display("t_full done");
    endtask
    // Different lane selects on the two beats
    task automatic t_lanes();
        logic [DW-1:0] q0, q1;
        logic          v;
        u_ctl.wr(4'h5, 18'h3_ffff, 18'h3_ffff, 2'h1, 2'h2);
        u_ctl.rd(4'h5, q0, q1, v);
        check("lane word0", q0, pat(1, 0) & 18'h0_01ff | 18'h3_fe00);
        check("lane word1", q1, pat(1, 1) & 18'h3_fe00 | 18'h0_01ff);
        $display("t_lanes done");
    endtask
    // Load in a complement cycle is ignored
    task automatic t_refused();
        int beats;
        u_ctl.odd_load(beats);
        check("odd load beats", DW'(beats), '0);
        $display("t_refused done");
    endtask
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        repeat (10) @(posedge core_clk);
        check("oe", dq_oe, 1'b0);
        check("echo", echo_out, DBP_ECHO_RESET);
        check("echo_n", echo_out_n, !DBP_ECHO_RESET);
        #1;
        rst_b = 1'b1;
        t_full();
        t_lanes();
        t_refused();
        close_out();
    end
endmodule

// ===== verilog/dbp_array.sv
// One storage array with per-lane write enables
`timescale 1ns/1ps
module dbp_array
    import dbp_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 21,
    parameter int LANES  = 2
) (
    // Clock
    input  wire logic core_clk,
    // Array access
    dbp_mem_if.mem    port
);
    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] store [DEPTH];
    logic [DATA_W-1:0] next_word;

    ////////////////////////////////////////////////////////////////////////////
    // Merge enabled lanes into the stored word
    always_comb begin
        next_word = store[port.waddr];
        for (int i = 0; i < LANES; i++) begin
            if (port.wbe[i]) begin
                next_word[i*DBP_LANE_W +: DBP_LANE_W] = port.wdata[i*DBP_LANE_W +: DBP_LANE_W];
            end
        end
    end

    // Storage update, no reset on contents
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            store[port.waddr] <= next_word;
        end
    end

    // Asynchronous read by index
    assign port.rdata = store[port.raddr];
endmodule

// ===== verilog/dbp_mem_if.sv
// Connection between the port logic and one storage array
`timescale 1ns/1ps
interface dbp_mem_if #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 21,
    parameter int LANES  = 2
);
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  wbe;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output wbe, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input wbe, input raddr,
                  output rdata);
endinterface

// ===== verilog/dbp_pkg.sv
// Shared constants for the two-word burst DDR static RAM port
package dbp_pkg;
    localparam int          DBP_DATA_W_NARROW = 18;       // Narrow variant data width
    localparam int          DBP_ADDR_W_NARROW = 21;       // 2M burst locations, 4M words
    localparam int          DBP_LANE_W        = 9;        // Bits gated by one write select
    localparam int          DBP_BURST_LEN     = 2;        // Words per transaction
    localparam logic        DBP_PHASE_K       = 1'b0;     // Cycle ending on a true clock edge
    localparam logic        DBP_PHASE_KB      = 1'b1;     // Cycle ending on a complement edge
    localparam logic        DBP_DIR_READ      = 1'b1;     // Direction input level for a read
    localparam logic        DBP_ECHO_RESET    = 1'b1;     // Echo clock level after reset

    // Kind of access held in a pipeline stage
    typedef enum logic [1:0] {
        DBP_IDLE,
        DBP_READ,
        DBP_WRITE
    } dbp_op_t;
endpackage

// ===== verilog/dbp_port.sv
// Two-word burst DDR static RAM port, device side
// Contract
// - Write data is captured on both the true and complementary clock edges of a write.
// - Read data is launched on both the true and complementary clock edges of a read.
// - The data outputs are released whenever no read beat is being driven.
// - Load is sampled active low on the true clock edge with address and direction.
// - Each loaded transaction moves exactly two words.
// - Direction high at load means read, low means write.
// - One address bus is sampled on the true edge for both reads and writes.
// - Accesses start only on a true clock edge, which also captures and launches data.
// - The complementary edge captures and launches data in alternation with the true edge.
// - Each active-low write select gates one nine-bit lane, lane zero lowest.
// - Write selects are sampled on the same edge as the data word they qualify.
// - A lane whose select is high keeps its stored content.
// - Storage is two arrays, one per burst word, each of half the total words.
// - Output valid is high while read data is valid and changes with the echo clocks.
// - A free-running pair of echo clocks follows the true input clock.
`timescale 1ns/1ps
module dbp_port
    import dbp_pkg::*;
#(
    // Data word width, 18 or 36
    parameter int DATA_W = DBP_DATA_W_NARROW,
    // Burst address width
    parameter int ADDR_W = DBP_ADDR_W_NARROW,
    // Write lanes, one per nine data bits
    parameter int LANES  = DATA_W / DBP_LANE_W
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Command inputs
    input  wire logic              load_n,
    input  wire logic              read_not_write,
    input  wire logic [ADDR_W-1:0] addr,
    // Write data and lane selects
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic [LANES-1:0]  byte_write_sel_n,
    // Read data pins
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   output_valid,
    // Echo clocks
    output logic                   echo_out,
    output logic                   echo_out_n
);
    // Phase of the current cycle: true or complementary clock edge at its end
    logic              phase;
    logic              next_phase;

    // Echo clock next values
    logic              next_echo;
    logic              next_echo_n;

    // Stage one: command taken at the last true edge
    dbp_op_t           s1_op;
    dbp_op_t           next_s1_op;
    logic [ADDR_W-1:0] s1_addr;
    logic [ADDR_W-1:0] next_s1_addr;

    // Stage two: command awaiting its second write beat
    dbp_op_t           s2_op;
    dbp_op_t           next_s2_op;
    logic [ADDR_W-1:0] s2_addr;
    logic [ADDR_W-1:0] next_s2_addr;

    // Read data next value
    logic [DATA_W-1:0] next_dq_out;

    // Drive enable next value
    logic              next_dq_oe;

    // Output valid next value
    logic              next_output_valid;

    // Write strobe and lane enables of beat 0
    logic              beat0_we;
    logic [LANES-1:0]  beat0_lanes;

    // Write strobe and lane enables of beat 1
    logic              beat1_we;
    logic [LANES-1:0]  beat1_lanes;

    // Array connections, one array per burst word
    dbp_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) beat0_if ();
    dbp_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) beat1_if ();

    ////////////////////////////////////////////////////////////////////////////
    // Decode the sampled direction into an operation
    function automatic dbp_op_t decode_op(input logic ld_n, input logic dir);
        if (ld_n) begin
            return DBP_IDLE;
        end else if (dir == DBP_DIR_READ) begin
            return DBP_READ;
        end else begin
            return DBP_WRITE;
        end
    endfunction

    // Active-low selects to lane enables
    function automatic logic [LANES-1:0] lane_enable(input logic [LANES-1:0] sel_n);
        return ~sel_n;
    endfunction

    // True when the edge closing this cycle is a true clock edge
    function automatic logic k_edge(input logic ph);
        return ph == DBP_PHASE_K;
    endfunction

    // Stage holds a write burst
    function automatic logic op_is_write(input dbp_op_t op);
        return op == DBP_WRITE;
    endfunction

    // Stage holds a read burst
    function automatic logic op_is_read(input dbp_op_t op);
        return op == DBP_READ;
    endfunction

    // Word launched at the edge closing a read cycle
    function automatic logic [DATA_W-1:0] launch_word(input logic              ph,
                                                      input logic [DATA_W-1:0] w0,
                                                      input logic [DATA_W-1:0] w1);
        if (k_edge(ph)) begin
            return w1;
        end else begin
            return w0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge phase next value
    always_comb begin
        next_phase = ~phase;
    end

    // Phase register, the first cycle after reset ends on a true edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= DBP_PHASE_K;
        end else begin
            phase <= next_phase;
        end
    end

    // True echo next value, high through cycles that end on a true edge
    always_comb begin
        next_echo = k_edge(next_phase);
    end

    // True echo register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_out <= DBP_ECHO_RESET;
        end else begin
            echo_out <= next_echo;
        end
    end

    // Complementary echo next value
    always_comb begin
        next_echo_n = ~k_edge(next_phase);
    end

    // Complementary echo register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_out_n <= ~DBP_ECHO_RESET;
        end else begin
            echo_out_n <= next_echo_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage one next values: a command is taken only on a true edge
    always_comb begin
        next_s1_op   = s1_op;
        next_s1_addr = s1_addr;
        if (k_edge(phase)) begin
            next_s1_op = decode_op(load_n, read_not_write);
            if (!load_n) begin
                next_s1_addr = addr;
            end
        end
    end

    // Stage one registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_op   <= DBP_IDLE;
            s1_addr <= '0;
        end else begin
            s1_op   <= next_s1_op;
            s1_addr <= next_s1_addr;
        end
    end

    // Stage two next values: the stage one command moves on at each true edge
    always_comb begin
        next_s2_op   = s2_op;
        next_s2_addr = s2_addr;
        if (k_edge(phase)) begin
            next_s2_op   = s1_op;
            next_s2_addr = s1_addr;
        end
    end

    // Stage two registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s2_op   <= DBP_IDLE;
            s2_addr <= '0;
        end else begin
            s2_op   <= next_s2_op;
            s2_addr <= next_s2_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Beat 0 strobe and lanes: the true edge after the load cycle
    always_comb begin
        beat0_we    = k_edge(phase) && op_is_write(s1_op);
        beat0_lanes = lane_enable(byte_write_sel_n);
    end

    // Beat 1 strobe and lanes: the complementary edge that follows
    always_comb begin
        beat1_we    = !k_edge(phase) && op_is_write(s2_op);
        beat1_lanes = lane_enable(byte_write_sel_n);
    end

    // First array port: word 0 of every burst
    assign beat0_if.we    = beat0_we;
    assign beat0_if.waddr = s1_addr;
    assign beat0_if.wdata = dq_in;
    assign beat0_if.wbe   = beat0_lanes;
    assign beat0_if.raddr = s1_addr;

    // Second array port: word 1 of every burst, read with the stage one address
    assign beat1_if.we    = beat1_we;
    assign beat1_if.waddr = s2_addr;
    assign beat1_if.wdata = dq_in;
    assign beat1_if.wbe   = beat1_lanes;
    assign beat1_if.raddr = s1_addr;

    // Array for word 0
    dbp_array #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_beat0 (
        .core_clk (core_clk),
        .port     (beat0_if)
    );

    // Array for word 1
    dbp_array #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_beat1 (
        .core_clk (core_clk),
        .port     (beat1_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Drive enable next value: high through both beats of a read
    always_comb begin
        next_dq_oe = op_is_read(s1_op);
    end

    // Drive enable register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_oe <= 1'b0;
        end else begin
            dq_oe <= next_dq_oe;
        end
    end

    // Read data next value: word 0 on the complementary edge, word 1 on the true edge
    always_comb begin
        if (!op_is_read(s1_op)) begin
            next_dq_out = '0;
        end else begin
            next_dq_out = launch_word(phase, beat0_if.rdata, beat1_if.rdata);
        end
    end

    // Read data register, a released bus shows zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= '0;
        end else begin
            dq_out <= next_dq_out;
        end
    end

    // Output valid next value, the same beats as the drive enable
    always_comb begin
        next_output_valid = op_is_read(s1_op);
    end

    // Output valid register, changes on the same edges as the echo clocks
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            output_valid <= 1'b0;
        end else begin
            output_valid <= next_output_valid;
        end
    end
endmodule
